// ===== logic/cfr_regs.svh
`ifndef CFR_REGS_SVH
`define CFR_REGS_SVH

// register byte offsets (low eight address bits)
`define CFR_OFS_CTRL       8'h00
`define CFR_OFS_PARAM      8'h04
`define CFR_OFS_FILE       8'h08
`define CFR_OFS_STATUS     8'h0C
`define CFR_OFS_BUF_IDX    8'h10
`define CFR_OFS_BUF_DATA   8'h14

// control fields
`define CFR_CTRL_START     0
`define CFR_CTRL_KIND_LO   1
`define CFR_CTRL_KIND_HI   2

// parameter word fields
`define CFR_PAR_P1_LO      0
`define CFR_PAR_P1_HI      7
`define CFR_PAR_P2_LO      8
`define CFR_PAR_P2_HI      15
`define CFR_PAR_LEN_LO     16
`define CFR_PAR_LEN_HI     23

// file descriptor fields
`define CFR_FIL_TYPE_LO    0
`define CFR_FIL_TYPE_HI    1
`define CFR_FIL_CNT_LO     8
`define CFR_FIL_CNT_HI     15
`define CFR_FIL_RLEN_LO    16
`define CFR_FIL_RLEN_HI    23
`define CFR_FIL_RD_OK      24
`define CFR_FIL_UPD_OK     25

// status fields
`define CFR_STA_BUSY       0
`define CFR_STA_DONE       1
`define CFR_STA_RES_LO     2
`define CFR_STA_RES_HI     4
`define CFR_STA_PTR_VALID  5
`define CFR_STA_SFI_USED   6
`define CFR_STA_PTR_LO     8
`define CFR_STA_SFI_LO     16
`define CFR_STA_XFER_LO    24

// sizes, codes and reset values
`define CFR_FILE_BYTES     16'h0100
`define CFR_SFI_RFU        5'h1F
`define CFR_MODE_NEXT      3'h2
`define CFR_MODE_PREV      3'h3
`define CFR_MODE_ABS       3'h4
`define CFR_P1_CURRENT     8'h00
`define CFR_SFI_NONE       5'h00
`define CFR_BIN_SFI_TAG    3'h4
`define CFR_RESP_OKAY      1'b0
`define CFR_ZERO_WORD      32'h0000_0000

`endif

// ===== logic/cfr_pkg.sv
package cfr_pkg;

    typedef enum logic [1:0] {
        CFR_READ_BIN,
        CFR_UPD_BIN,
        CFR_READ_REC,
        CFR_UPD_REC
    } cfr_kind_e;

    typedef enum logic [1:0] {
        CFR_TRANSPARENT,
        CFR_LINEAR,
        CFR_CYCLIC,
        CFR_TYPE_RFU
    } cfr_ftype_e;

    typedef enum logic [2:0] {
        CFR_RES_OK,
        CFR_RES_DENIED,
        CFR_RES_TYPE,
        CFR_RES_PARAM,
        CFR_RES_NODATA,
        CFR_RES_RANGE,
        CFR_RES_LEN
    } cfr_res_e;

    typedef enum logic {
        CFR_IDLE,
        CFR_RUN
    } cfr_state_e;

endpackage

// ===== logic/cfr_cmd_engine.sv
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "cfr_regs.svh"

module cfr_cmd_engine
    import cfr_pkg::*;
(
    input  wire logic        CLOCK_I,
    input  wire logic        RSTN_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    output logic             BUSY_O
);

    ////////////////////////////////////////////////////////////////////////
    // storage

    logic [7:0]  file_mem [0:255];
    logic [7:0]  io_buf   [0:255];

    logic        acc_pend;
    logic [7:0]  acc_addr;
    logic        acc_write;

    logic [7:0]  par_p1;
    logic [7:0]  par_p2;
    logic [7:0]  par_len;
    cfr_ftype_e  file_type;
    logic [7:0]  rec_count;
    logic [7:0]  rec_len;
    logic        rd_ok;
    logic        upd_ok;
    logic [7:0]  buf_idx;

    cfr_state_e  state;
    cfr_kind_e   kind;
    cfr_res_e    result;
    logic        done;
    logic [7:0]  ptr;
    logic        ptr_valid;
    logic [7:0]  head;
    logic [4:0]  short_file_ref;
    logic        sfi_used;
    logic [8:0]  xfer_cnt;
    logic [8:0]  xfer_total;
    logic [7:0]  xfer_base;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    logic        addr_phase;
    logic        wr_en;
    logic        start;
    cfr_kind_e   start_kind;

    assign addr_phase = HSEL_I & HTRANS_I[1] & HREADY_I;
    assign wr_en      = acc_pend & acc_write;
    assign start_kind = cfr_kind_e'(HWDATA_I[`CFR_CTRL_KIND_HI:`CFR_CTRL_KIND_LO]);
    // a start while busy is dropped; software polls busy first
    assign start      = wr_en & (acc_addr == `CFR_OFS_CTRL) & HWDATA_I[`CFR_CTRL_START] & (state == CFR_IDLE);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return acc_pend && (a == ofs);
    endfunction

    // maps logical record number onto its slot; head rotates cyclic files
    function automatic logic [7:0] phys_slot(input logic [7:0] rec,
                                              input logic [7:0] hd,
                                              input logic [7:0] cnt);
        logic [8:0] s;
        s = {1'b0, hd} + {1'b0, rec} - 9'h001;
        if (s >= {1'b0, cnt}) begin
            s = s - {1'b0, cnt};
        end
        return s[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // command decode

    cfr_res_e    dec_res;
    logic [7:0]  dec_base;
    logic [8:0]  dec_len;
    logic [7:0]  dec_ptr;
    logic        dec_pv;
    logic [7:0]  dec_head;
    logic [4:0]  dec_sfi;
    logic        dec_sfi_used;

    always_comb begin
        logic [14:0] off;
        logic [15:0] span;
        logic [15:0] rbase;
        logic [7:0]  rec;
        logic [2:0]  mode;
        off          = 15'h0000;
        span         = 16'h0000;
        rbase        = 16'h0000;
        rec          = 8'h00;
        mode         = par_p2[2:0];
        dec_res      = CFR_RES_OK;
        dec_base     = 8'h00;
        dec_len      = {1'b0, par_len};
        dec_ptr      = ptr;
        dec_pv       = ptr_valid;
        dec_head     = head;
        dec_sfi      = `CFR_SFI_NONE;
        dec_sfi_used = 1'b0;
        if (start_kind == CFR_READ_BIN || start_kind == CFR_UPD_BIN) begin
            if (!par_p1[7]) begin
                off = {par_p1[6:0], par_p2};
            end else if (par_p1[7:5] == `CFR_BIN_SFI_TAG) begin
                dec_sfi      = par_p1[4:0];
                dec_sfi_used = 1'b1;
                off          = {7'h00, par_p2};
            end else begin
                dec_res = CFR_RES_PARAM;
            end
            span = {1'b0, off} + {8'h00, par_len};
            if (dec_res == CFR_RES_OK) begin
                if (file_type != CFR_TRANSPARENT) begin
                    dec_res = CFR_RES_TYPE;
                end else if ((start_kind == CFR_READ_BIN) ? !rd_ok : !upd_ok) begin
                    dec_res = CFR_RES_DENIED;
                end else if (span > `CFR_FILE_BYTES) begin
                    dec_res = CFR_RES_RANGE;
                end
            end
            dec_base = off[7:0];
            dec_len  = {1'b0, par_len};
        end else begin
            dec_len = {1'b0, rec_len};
            if (par_p2[7:3] != `CFR_SFI_NONE) begin
                dec_sfi      = par_p2[7:3];
                dec_sfi_used = 1'b1;
            end
            if (par_p2[7:3] == `CFR_SFI_RFU) begin
                dec_res = CFR_RES_PARAM;
            end else if (file_type != CFR_LINEAR && file_type != CFR_CYCLIC) begin
                dec_res = CFR_RES_TYPE;
            end else if ((start_kind == CFR_READ_REC) ? !rd_ok : !upd_ok) begin
                dec_res = CFR_RES_DENIED;
            end else if ({8'h00, rec_count} * {8'h00, rec_len} > `CFR_FILE_BYTES || rec_count == 8'h00) begin
                dec_res = CFR_RES_RANGE;
            end else if (start_kind == CFR_UPD_REC && par_len != rec_len) begin
                dec_res = CFR_RES_LEN;
            end else if (start_kind == CFR_UPD_REC && file_type == CFR_CYCLIC && mode != `CFR_MODE_PREV) begin
                dec_res = CFR_RES_PARAM;
            end else begin
                // P1 is not looked at in next/previous; the terminal zeroes it
                unique case (mode)
                    `CFR_MODE_ABS: begin
                        if (par_p1 == `CFR_P1_CURRENT) begin
                            rec = ptr;
                            if (!ptr_valid) begin
                                dec_res = CFR_RES_NODATA;
                            end
                        end else begin
                            rec = par_p1;
                            if (par_p1 > rec_count) begin
                                dec_res = CFR_RES_RANGE;
                            end
                        end
                    end
                    `CFR_MODE_NEXT: begin
                        if (!ptr_valid) begin
                            rec = 8'h01;
                        end else if (ptr == rec_count) begin
                            if (file_type == CFR_CYCLIC) begin
                                rec = 8'h01;
                            end else begin
                                dec_res = CFR_RES_NODATA;
                            end
                        end else begin
                            rec = ptr + 8'h01;
                        end
                        dec_ptr = rec;
                        dec_pv  = 1'b1;
                    end
                    `CFR_MODE_PREV: begin
                        if (start_kind == CFR_UPD_REC && file_type == CFR_CYCLIC) begin
                            rec      = rec_count;
                            dec_head = phys_slot(rec_count, head, rec_count);
                            dec_ptr  = 8'h01;
                        end else if (!ptr_valid) begin
                            rec     = rec_count;
                            dec_ptr = rec;
                        end else if (ptr == 8'h01) begin
                            if (file_type == CFR_CYCLIC) begin
                                rec = rec_count;
                            end else begin
                                dec_res = CFR_RES_NODATA;
                            end
                            dec_ptr = rec;
                        end else begin
                            rec     = ptr - 8'h01;
                            dec_ptr = rec;
                        end
                        dec_pv = 1'b1;
                    end
                    default: begin
                        dec_res = CFR_RES_PARAM;
                    end
                endcase
            end
            rbase    = {8'h00, phys_slot(rec, head, rec_count)} * {8'h00, rec_len};
            dec_base = rbase[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, data registered

    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [31:0] w;
        w = `CFR_ZERO_WORD;
        unique case (a)
            `CFR_OFS_CTRL: begin
                w[`CFR_CTRL_KIND_HI:`CFR_CTRL_KIND_LO] = kind;
            end
            `CFR_OFS_PARAM: begin
                w = {8'h00, par_len, par_p2, par_p1};
            end
            `CFR_OFS_FILE: begin
                w = {6'h00, upd_ok, rd_ok, rec_len, rec_count, 6'h00, file_type};
            end
            `CFR_OFS_STATUS: begin
                w[`CFR_STA_BUSY]                      = (state == CFR_RUN);
                w[`CFR_STA_DONE]                      = done;
                w[`CFR_STA_RES_HI:`CFR_STA_RES_LO]    = result;
                w[`CFR_STA_PTR_VALID]                 = ptr_valid;
                w[`CFR_STA_SFI_USED]                  = sfi_used;
                w[`CFR_STA_PTR_LO+7:`CFR_STA_PTR_LO]  = ptr;
                w[`CFR_STA_SFI_LO+4:`CFR_STA_SFI_LO]  = short_file_ref;
                w[`CFR_STA_XFER_LO+7:`CFR_STA_XFER_LO] = xfer_cnt[7:0];
            end
            `CFR_OFS_BUF_IDX: begin
                w[7:0] = buf_idx;
            end
            `CFR_OFS_BUF_DATA: begin
                w[7:0] = io_buf[buf_idx];
            end
            default: begin
                w = `CFR_ZERO_WORD;
            end
        endcase
        return w;
    endfunction

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            acc_pend    <= 1'b0;
            acc_addr    <= 8'h00;
            acc_write   <= 1'b0;
            HREADYOUT_O <= 1'b1;
            HRDATA_O    <= `CFR_ZERO_WORD;
            HRESP_O     <= `CFR_RESP_OKAY;
        end else begin
            HRESP_O <= `CFR_RESP_OKAY;
            if (acc_pend) begin
                acc_pend    <= 1'b0;
                HREADYOUT_O <= 1'b1;
                HRDATA_O    <= acc_write ? `CFR_ZERO_WORD : rd_word(acc_addr);
            end else if (addr_phase) begin
                // upper address bits ignored: the map aliases every 256 bytes
                acc_pend    <= 1'b1;
                acc_addr    <= {HADDR_I[7:2], 2'b00};
                acc_write   <= HWRITE_I;
                HREADYOUT_O <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            par_p1  <= 8'h00;
            par_p2  <= 8'h00;
            par_len <= 8'h00;
        end else if (wr_en && hit(acc_addr, `CFR_OFS_PARAM)) begin
            par_p1  <= HWDATA_I[`CFR_PAR_P1_HI:`CFR_PAR_P1_LO];
            par_p2  <= HWDATA_I[`CFR_PAR_P2_HI:`CFR_PAR_P2_LO];
            par_len <= HWDATA_I[`CFR_PAR_LEN_HI:`CFR_PAR_LEN_LO];
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            file_type <= CFR_TRANSPARENT;
            rec_count <= 8'h00;
            rec_len   <= 8'h00;
            rd_ok     <= 1'b0;
            upd_ok    <= 1'b0;
        end else if (wr_en && hit(acc_addr, `CFR_OFS_FILE) && state == CFR_IDLE) begin
            file_type <= cfr_ftype_e'(HWDATA_I[`CFR_FIL_TYPE_HI:`CFR_FIL_TYPE_LO]);
            rec_count <= HWDATA_I[`CFR_FIL_CNT_HI:`CFR_FIL_CNT_LO];
            rec_len   <= HWDATA_I[`CFR_FIL_RLEN_HI:`CFR_FIL_RLEN_LO];
            rd_ok     <= HWDATA_I[`CFR_FIL_RD_OK];
            upd_ok    <= HWDATA_I[`CFR_FIL_UPD_OK];
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            buf_idx <= 8'h00;
        end else if (wr_en && hit(acc_addr, `CFR_OFS_BUF_IDX)) begin
            buf_idx <= HWDATA_I[7:0];
        end else if (hit(acc_addr, `CFR_OFS_BUF_DATA)) begin
            buf_idx <= buf_idx + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transfer engine

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state      <= CFR_IDLE;
            kind       <= CFR_READ_BIN;
            result     <= CFR_RES_OK;
            done       <= 1'b0;
            xfer_cnt   <= 9'h000;
            xfer_total <= 9'h000;
            xfer_base  <= 8'h00;
            short_file_ref        <= `CFR_SFI_NONE;
            sfi_used   <= 1'b0;
            BUSY_O     <= 1'b0;
        end else begin
            unique case (state)
                CFR_IDLE: begin
                    if (start) begin
                        kind       <= start_kind;
                        result     <= dec_res;
                        short_file_ref        <= dec_sfi;
                        sfi_used   <= dec_sfi_used;
                        xfer_cnt   <= 9'h000;
                        xfer_total <= dec_len;
                        xfer_base  <= dec_base;
                        // refused commands finish at once and move no bytes
                        done       <= (dec_res != CFR_RES_OK);
                        state      <= (dec_res == CFR_RES_OK) ? CFR_RUN : CFR_IDLE;
                        BUSY_O     <= (dec_res == CFR_RES_OK);
                    end
                end
                CFR_RUN: begin
                    if (xfer_cnt == xfer_total) begin
                        done   <= 1'b1;
                        state  <= CFR_IDLE;
                        BUSY_O <= 1'b0;
                    end else begin
                        xfer_cnt <= xfer_cnt + 9'h001;
                    end
                end
            endcase
        end
    end

    // pointer and head change only when a record command is accepted or, cleared, when the file descriptor is written
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ptr       <= 8'h00;
            ptr_valid <= 1'b0;
            head      <= 8'h00;
        end else if (wr_en && hit(acc_addr, `CFR_OFS_FILE) && state == CFR_IDLE) begin
            ptr       <= 8'h00;
            ptr_valid <= 1'b0;
            head      <= 8'h00;
        end else if (start && dec_res == CFR_RES_OK && (start_kind == CFR_READ_REC || start_kind == CFR_UPD_REC)) begin
            ptr       <= dec_ptr;
            ptr_valid <= dec_pv;
            head      <= dec_head;
        end
    end

    // one byte per cycle; failed commands never reach here, so no state moves
    always_ff @(posedge CLOCK_I) begin
        if (state == CFR_RUN && xfer_cnt != xfer_total && (kind == CFR_UPD_BIN || kind == CFR_UPD_REC)) begin
            file_mem[xfer_base + xfer_cnt[7:0]] <= io_buf[xfer_cnt[7:0]];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (state == CFR_RUN && xfer_cnt != xfer_total && (kind == CFR_READ_BIN || kind == CFR_READ_REC)) begin
            io_buf[xfer_cnt[7:0]] <= file_mem[xfer_base + xfer_cnt[7:0]];
        end else if (wr_en && hit(acc_addr, `CFR_OFS_BUF_DATA)) begin
            io_buf[buf_idx] <= HWDATA_I[7:0];
        end
    end

endmodule

// ===== verif/cfr_checker.sv
`timescale 1ns/1ns
module cfr_checker (
    input  wire logic        CLOCK_I,
    input  wire logic        RSTN_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    input  wire logic [31:0] HRDATA_O,
    input  wire logic        HREADYOUT_O,
    input  wire logic        HRESP_O,
    input  wire logic        BUSY_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);
    logic       taken;
    logic       taken_wr;
    logic       start_ap;
    logic       start_bit;
    logic [8:0] busy_run;
    assign taken     = HSEL_I && HTRANS_I[1] && HREADY_I;
    assign taken_wr  = taken && HWRITE_I;
    assign start_ap  = taken_wr && (HADDR_I[7:2] == 6'h00);
    assign start_bit = HWDATA_I[0];
    // a counter, since a deep repetition would stall the tools
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            busy_run <= 9'h000;
        end else begin
            busy_run <= BUSY_O ? busy_run + 9'h001 : 9'h000;
        end
    end
    ////////////////////////////////////////////////////////////////
    AST_RESP_OKAY:
        assert property (HRESP_O == 1'b0) else $error("error response seen");
    AST_ONE_WAIT:
        assert property (taken |=> !HREADYOUT_O ##1 HREADYOUT_O) else $error("wait state not exactly one");
    AST_READY_IDLE:
        assert property (!$past(taken) |-> HREADYOUT_O) else $error("ready low without transfer");
    AST_WR_ZERO:
        assert property ($past(taken_wr, 2) |-> HRDATA_O == 32'h0000_0000) else $error("read data not zero after write");
    AST_RDATA_HOLD:
        assert property ($changed(HRDATA_O) |-> $past(taken, 2)) else $error("read data moved between transfers");
    AST_BUSY_CAUSE:
        assert property ($rose(BUSY_O) |-> $past(start_ap, 2) && $past(start_bit)) else $error("busy without start");
    AST_BUSY_BOUND:
        assert property (busy_run <= 9'h101) else $error("busy too long");
    AST_RESET_QUIET:
        assert property ($rose(RSTN_I) |-> HREADYOUT_O && !BUSY_O) else $error("outputs not idle after reset");
endmodule

bind cfr_cmd_engine cfr_checker cfr_checker_i (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .HSEL_I(HSEL_I),
    .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
    .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .BUSY_O(BUSY_O));

// ===== verif/cfr_term_model.sv
`timescale 1ns/1ns
`include "cfr_regs.svh"
module cfr_term_model (
    input  wire logic        CLOCK_I,
    input  wire logic        HREADY_I,
    input  wire logic [31:0] HRDATA_I,
    output logic             HSEL_O,
    output logic [31:0]      HADDR_O,
    output logic [1:0]       HTRANS_O,
    output logic             HWRITE_O,
    output logic [31:0]      HWDATA_O
);
    initial begin
        HSEL_O   = 1'b0;
        HADDR_O  = 32'h0000_0000;
        HTRANS_O = 2'h0;
        HWRITE_O = 1'b0;
        HWDATA_O = 32'h0000_0000;
    end
    // waits as long as the slave stalls; only the bench timeout ends it
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge CLOCK_I);
        HSEL_O   <= 1'b1;
        HTRANS_O <= 2'h2;
        HADDR_O  <= {24'h000000, a};
        HWRITE_O <= w;
        do @(posedge CLOCK_I); while (!HREADY_I);
        HSEL_O   <= 1'b0;
        HTRANS_O <= 2'h0;
        HWDATA_O <= d;
        do @(posedge CLOCK_I); while (!HREADY_I);
        q = HRDATA_I;
        // released data lines must not look valid
        HWDATA_O <= ~d;
    endtask
    // length field carries Le for reads, Lc for updates
    // P2 is a plain offset in binary commands, so only record commands in next or previous mode zero P1
    task automatic param(input logic is_rec, input logic [7:0] p1, input logic [7:0] p2,
                         input logic [7:0] ln);
        logic [31:0] q;
        if (is_rec && p2[2:1] == 2'b01) begin
            p1 = 8'h00;
        end
        xfer(1'b1, `CFR_OFS_PARAM, {8'h00, ln, p2, p1}, q);
    endtask
endmodule

// ===== verif/tb_cfr_cmd_engine.sv
`timescale 1ns/1ns
`include "cfr_regs.svh"
module tb_cfr_cmd_engine;
    import cfr_pkg::*;
    logic        clk;
    logic        rstn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic [31:0] st;
    logic [31:0] q;
    int          fails;
    int          n_compared;
    int          cyc;
    int          i;
    cfr_cmd_engine cfr_cmd_engine_i (.CLOCK_I(clk), .RSTN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .BUSY_O());
    cfr_term_model cfr_term_model_i (.CLOCK_I(clk), .HREADY_I(hready), .HRDATA_I(hrdata), .HSEL_O(hsel),
        .HADDR_O(haddr), .HTRANS_O(htrans), .HWRITE_O(hwrite), .HWDATA_O(hwdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared = n_compared + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        cfr_term_model_i.xfer(1'b1, a, d, q);
    endtask
    // code 7 is unused, so it marks a result left unchecked
    task run(input cfr_kind_e k, input logic [7:0] p1, input logic [7:0] p2, input logic [7:0] ln,
             input logic [2:0] e);
        cfr_term_model_i.param(k == CFR_READ_REC || k == CFR_UPD_REC, p1, p2, ln);
        wr(`CFR_OFS_CTRL, {29'h0, k, 1'b1});
        st = 32'h0;
        for (int n = 0; n < 300 && st[1] !== 1'b1; n++) begin
            cfr_term_model_i.xfer(1'b0, `CFR_OFS_STATUS, 32'h0, st);
        end
        // a poll that runs out without done must not pass silently
        chk(32'(st[1]), 32'h1);
        if (e != 3'h7) begin
            chk(32'(st[4:2]), 32'(e));
        end
    endtask
    task buf_put(input logic [15:0] v);
        wr(`CFR_OFS_BUF_IDX, 32'h0);
        wr(`CFR_OFS_BUF_DATA, {24'h0, v[7:0]});
        wr(`CFR_OFS_BUF_DATA, {24'h0, v[15:8]});
    endtask
    task buf_chk(input logic [15:0] v);
        logic [31:0] lo;
        wr(`CFR_OFS_BUF_IDX, 32'h0);
        cfr_term_model_i.xfer(1'b0, `CFR_OFS_BUF_DATA, 32'h0, lo);
        cfr_term_model_i.xfer(1'b0, `CFR_OFS_BUF_DATA, 32'h0, q);
        chk({16'h0, q[7:0], lo[7:0]}, {16'h0, v});
    endtask
    task rec(input cfr_kind_e k, input logic [7:0] p1, input logic [7:0] p2, input cfr_res_e e,
             input logic [7:0] ptr);
        run(k, p1, p2, 8'h02, e);
        chk(32'(st[15:8]), 32'(ptr));
    endtask
    initial begin
        fails = 0;
        n_compared = 0;
        cyc = 0;
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        // transparent file, update only
        wr(`CFR_OFS_FILE, 32'h0200_0000);
        buf_put(16'hB2A1);
        run(CFR_UPD_BIN, 8'h00, 8'h10, 8'h02, CFR_RES_OK);
        run(CFR_READ_BIN, 8'h85, 8'h10, 8'h02, CFR_RES_DENIED);
        wr(`CFR_OFS_FILE, 32'h0300_0000);
        buf_put(16'h0000);
        run(CFR_READ_BIN, 8'h85, 8'h10, 8'h02, CFR_RES_OK);
        chk(32'(st[31:24]), 32'h2);
        chk(32'(st[20:16]), 32'h5);
        buf_chk(16'hB2A1);
        run(CFR_UPD_BIN, 8'h01, 8'h00, 8'h01, CFR_RES_RANGE);
        // linear fixed, three records of two bytes
        wr(`CFR_OFS_FILE, 32'h0302_0301);
        for (i = 1; i <= 3; i++) begin
            buf_put(16'(16'h1001 * i));
            rec(CFR_UPD_REC, 8'(i), 8'h04, CFR_RES_OK, 8'h00);
        end
        for (i = 1; i <= 3; i++) begin
            rec(CFR_READ_REC, 8'h00, 8'h02, CFR_RES_OK, 8'(i));
            buf_chk(16'(16'h1001 * i));
        end
        rec(CFR_READ_REC, 8'h00, 8'h02, CFR_RES_NODATA, 8'h03);
        rec(CFR_READ_REC, 8'h55, 8'h03, CFR_RES_OK, 8'h02);
        buf_chk(16'h2002);
        rec(CFR_READ_REC, 8'h00, 8'h03, CFR_RES_OK, 8'h01);
        rec(CFR_READ_REC, 8'h00, 8'h03, CFR_RES_NODATA, 8'h01);
        rec(CFR_READ_REC, 8'h03, 8'h04, CFR_RES_OK, 8'h01);
        buf_chk(16'h3003);
        rec(CFR_READ_REC, 8'h00, 8'h0C, CFR_RES_OK, 8'h01);
        chk(32'(st[20:16]), 32'h1);
        buf_chk(16'h1001);
        rec(CFR_READ_REC, 8'h00, 8'h05, CFR_RES_PARAM, 8'h01);
        rec(CFR_READ_REC, 8'h00, 8'hFC, CFR_RES_PARAM, 8'h01);
        run(CFR_UPD_REC, 8'h02, 8'h04, 8'h01, CFR_RES_LEN);
        // update-only file: pointer moves by updates, failed read keeps it
        wr(`CFR_OFS_FILE, 32'h0202_0301);
        rec(CFR_UPD_REC, 8'h00, 8'h02, CFR_RES_OK, 8'h01);
        rec(CFR_READ_REC, 8'h00, 8'h02, CFR_RES_DENIED, 8'h01);
        rec(CFR_UPD_REC, 8'h00, 8'h03, CFR_RES_NODATA, 8'h01);
        rec(CFR_UPD_REC, 8'h00, 8'h02, CFR_RES_OK, 8'h02);
        rec(CFR_UPD_REC, 8'h00, 8'h02, CFR_RES_OK, 8'h03);
        rec(CFR_UPD_REC, 8'h00, 8'h02, CFR_RES_NODATA, 8'h03);
        rec(CFR_UPD_REC, 8'h00, 8'h03, CFR_RES_OK, 8'h02);
        wr(`CFR_OFS_FILE, 32'h0302_0301);
        rec(CFR_READ_REC, 8'h00, 8'h03, CFR_RES_OK, 8'h03);
        wr(`CFR_OFS_FILE, 32'h0202_0301);
        rec(CFR_UPD_REC, 8'h00, 8'h03, CFR_RES_OK, 8'h03);
        // cyclic: each previous update lands on the oldest record
        wr(`CFR_OFS_FILE, 32'h0302_0302);
        buf_put(16'hA1A2);
        rec(CFR_UPD_REC, 8'h00, 8'h03, CFR_RES_OK, 8'h01);
        buf_put(16'hB1B2);
        rec(CFR_UPD_REC, 8'h00, 8'h03, CFR_RES_OK, 8'h01);
        buf_put(16'hC1C2);
        rec(CFR_UPD_REC, 8'h00, 8'h03, CFR_RES_OK, 8'h01);
        rec(CFR_READ_REC, 8'h02, 8'h04, CFR_RES_OK, 8'h01);
        buf_chk(16'hB1B2);
        rec(CFR_READ_REC, 8'h00, 8'h03, CFR_RES_OK, 8'h03);
        buf_chk(16'hA1A2);
        rec(CFR_READ_REC, 8'h00, 8'h02, CFR_RES_OK, 8'h01);
        buf_chk(16'hC1C2);
        run(CFR_UPD_REC, 8'h00, 8'h02, 8'h02, 3'h7);
        chk(32'(st[4:2] != 3'h0), 32'h1);
        chk(32'(st[15:8]), 32'h1);
        report_and_stop();
    end
endmodule
